// ---- logic/eas_map.svh ----
/*
  Constants of the event/action sequencer: register offsets, field
  positions, reset values, selector codes and scan timing.
  Assumes it is included by bare name from logic/ sources.
*/
`ifndef EAS_MAP_SVH
`define EAS_MAP_SVH

`define EAS_CLK_NS      4
`define EAS_SCAN_NS     1000000
`define EAS_SCAN_CYC    (`EAS_SCAN_NS / `EAS_CLK_NS)
`define EAS_RAMP_STEP   8'h01

`define EAS_A_CTRL      8'h00
`define EAS_A_COUNT     8'h04
`define EAS_A_TIMER0    8'h08
`define EAS_A_PRESET0   8'h0c
`define EAS_A_PRESET1   8'h10
`define EAS_A_TERM18    8'h14
`define EAS_A_TERM27    8'h18
`define EAS_A_STATUS    8'h1c
`define EAS_A_EVT_BASE  8'h40
`define EAS_A_ACT_BASE  8'ha0
`define EAS_A_WIN_MASK  8'hc0

`define EAS_CTRL_MODE   0
`define EAS_ST_RUN      0
`define EAS_ST_SEL      1
`define EAS_ST_TDONE    2
`define EAS_ST_ATREF    3
`define EAS_ST_IDX      8
`define EAS_ST_SPEED    16

`define EAS_TMR0_RST    16'h07d0
`define EAS_T18_RST     8'h08
`define EAS_T27_RST     8'h02

`define EAS_EV_FALSE    8'h00
`define EAS_EV_TRUE     8'h01
`define EAS_EV_ATREF    8'h04
`define EAS_EV_TMR0     8'h1e
`define EAS_AC_NONE     8'h01
`define EAS_AC_PRE0     8'h0a
`define EAS_AC_PRE1     8'h0b
`define EAS_AC_TMR0     8'h1d
`define EAS_T18_START   8'h08
`define EAS_T18_LATCH   8'h09
`define EAS_T27_NOP     8'h00
`define EAS_T27_COAST   8'h02
`define EAS_T27_STOPN   8'h06

`endif

// ---- logic/eas_pkg.sv ----
/*
  Types of the event/action sequencer.
  Assumes eas_map.svh holds the numeric constants.
*/
package eas_pkg;
  typedef enum logic [2:0] {
    EAS_FREE = 3'b001,
    EAS_RUN  = 3'b010,
    EAS_STOP = 3'b100
  } eas_drv_t;
endpackage

// ---- logic/eas_timer.sv ----
/*
  One-shot timer counted in scan ticks; expiry stays set until restart.
  Assumes tick is a one-cycle pulse on clk.
*/
`timescale 1ns/1ps
module eas_timer (
  input  wire logic        clk,     // system clock
  input  wire logic        rstn,    // synchronous reset, active low
  input  wire logic        tick,    // scan tick pulse
  input  wire logic        start,   // load and run
  input  wire logic [15:0] load,    // duration in scan ticks
  output logic             expired  // duration has elapsed
);
  logic [15:0] cnt_r;
  logic        run_r;
  logic        exp_r;

  assign expired = exp_r;

  // a start in the same cycle as a count wins, so a restart is never lost
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_r <= 16'h0000;
      run_r <= 1'b0;
      exp_r <= 1'b0;
    end else if (start) begin
      cnt_r <= load;
      run_r <= (load != 16'h0000);
      exp_r <= (load == 16'h0000);
    end else if (tick && run_r) begin
      cnt_r <= cnt_r - 16'h0001;
      if (cnt_r == 16'h0001) begin
        run_r <= 1'b0;
        exp_r <= 1'b1;
      end
    end
  end
endmodule

// ---- logic/eas_seq.sv ----
/*
  Event/action sequencer with start/stop terminal decode and speed ramp.
  Assumes a plain register port on clk; terminal pins are asynchronous.
*/
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "eas_map.svh"
module eas_seq
  import eas_pkg::*;
#(
  parameter int MAX_PAIRS = 20,            // event/action array depth
  parameter int SCAN_CYC  = `EAS_SCAN_CYC  // clock cycles per scan tick
) (
  input  wire logic        clk,        // 250 MHz system clock
  input  wire logic        rstn,       // synchronous reset, active low
  input  wire logic [7:0]  addr,       // register byte address
  input  wire logic [31:0] wdata,      // register write data
  input  wire logic        wr,         // write strobe
  input  wire logic        rd,         // read strobe
  output logic      [31:0] rdata,      // read data, cycle after rd
  input  wire logic        din18,      // start terminal pin
  input  wire logic        din27,      // second terminal pin
  output logic             drv_on,     // output stage powered
  output logic      [7:0]  speed,      // actual speed, percent of max
  output logic             ref_sel,    // active preset reference
  output logic             scan_tick   // scan tick pulse
);

  generate
    if (MAX_PAIRS < 1 || MAX_PAIRS > 20) begin : g_chk_pairs
      $error("MAX_PAIRS must lie in 1..20");
    end
    if (SCAN_CYC < 2) begin : g_chk_scan
      $error("SCAN_CYC must be at least 2");
    end
  endgenerate

  localparam int IW = 5;

  // register state
  logic        mode_r;
  logic [IW-1:0] count_r;
  logic [15:0] tmr0_r;
  logic [7:0]  pre0_r;
  logic [7:0]  pre1_r;
  logic [7:0]  t18_r;
  logic [7:0]  t27_r;
  logic [7:0]  evt_r [MAX_PAIRS];
  logic [7:0]  act_r [MAX_PAIRS];
  logic [31:0] rdata_r;

  // sequencer and drive state
  logic [IW-1:0] idx_r;
  logic [IW-1:0] idx_nxt;
  logic        sel_r;
  logic [7:0]  speed_r;
  logic [7:0]  speed_nxt;
  eas_drv_t    drv_r;
  eas_drv_t    drv_nxt;
  logic        latch_r;
  logic [31:0] scan_cnt_r;
  logic        tick_r;

  // pin synchronisers
  logic [1:0]  s18_r;
  logic [1:0]  s27_r;
  logic        s18_d_r;

  // scan tick
  always_ff @(posedge clk) begin
    if (!rstn) begin
      scan_cnt_r <= 32'h0000_0000;
      tick_r     <= 1'b0;
    end else begin
      tick_r     <= (scan_cnt_r == 32'(SCAN_CYC - 1));
      if (scan_cnt_r == 32'(SCAN_CYC - 1))
        scan_cnt_r <= 32'h0000_0000;
      else
        scan_cnt_r <= scan_cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s18_r   <= 2'b00;
      s27_r   <= 2'b00;
      s18_d_r <= 1'b0;
    end else begin
      s18_r   <= {s18_r[0], din18};
      s27_r   <= {s27_r[0], din27};
      s18_d_r <= s18_r[1];
    end
  end

  // register decode
  // each window spans twenty-four words, so a power-of-two mask cannot split them
  wire         in_evt  = (addr >= `EAS_A_EVT_BASE) && (addr < `EAS_A_ACT_BASE);
  wire         in_act  = (addr >= `EAS_A_ACT_BASE);
  wire [7:0]   evt_off = addr - `EAS_A_EVT_BASE;
  wire [7:0]   act_off = addr - `EAS_A_ACT_BASE;
  wire [5:0]   win_idx = addr[7:2] & 6'h0f | {addr[6] & 1'b0, 5'h00};
  wire [4:0]   ent     = {addr[6] & 1'b0, addr[5:2]} | 5'h00;
  wire [4:0]   ent_w   = addr[6:2] & 5'h1f;
  wire [4:0]   ent_i   = {1'b0, addr[5:2]} | {ent_w[4] & 1'b0, 4'h0};
  wire [4:0]   e_ix    = in_evt ? evt_off[6:2] : act_off[6:2];
  wire         e_ok    = (addr[1:0] == 2'b00)
                         && ({27'h0, e_ix} < 32'(MAX_PAIRS));
  wire         wr_ctrl = wr && addr == `EAS_A_CTRL;
  wire         wr_cnt  = wr && addr == `EAS_A_COUNT;

  // a count above the array depth is clipped to the depth
  wire [IW-1:0] cnt_w = (wdata[7:0] > 8'(MAX_PAIRS)) ?
                        IW'(MAX_PAIRS) : wdata[IW-1:0];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_r  <= 1'b0;
      count_r <= '0;
      tmr0_r  <= `EAS_TMR0_RST;
      pre0_r  <= 8'h00;
      pre1_r  <= 8'h00;
      t18_r   <= `EAS_T18_RST;
      t27_r   <= `EAS_T27_RST;
    end else if (wr) begin
      if (wr_ctrl)
        mode_r <= wdata[`EAS_CTRL_MODE];
      if (wr_cnt)
        count_r <= cnt_w;
      if (addr == `EAS_A_TIMER0)
        tmr0_r <= wdata[15:0];
      if (addr == `EAS_A_PRESET0)
        pre0_r <= (wdata[7:0] > 8'h64) ? 8'h64 : wdata[7:0];
      if (addr == `EAS_A_PRESET1)
        pre1_r <= (wdata[7:0] > 8'h64) ? 8'h64 : wdata[7:0];
      if (addr == `EAS_A_TERM18)
        t18_r <= wdata[7:0];
      if (addr == `EAS_A_TERM27)
        t27_r <= wdata[7:0];
    end
  end

  // event and action arrays, one entry per generate step
  genvar gi;
  generate
    for (gi = 0; gi < MAX_PAIRS; gi++) begin : g_pair
      always_ff @(posedge clk) begin
        if (!rstn) begin
          evt_r[gi] <= `EAS_EV_FALSE;
          act_r[gi] <= `EAS_AC_NONE;
        end else if (wr && e_ok && e_ix == 5'(gi)) begin
          if (in_evt)
            evt_r[gi] <= wdata[7:0];
          if (in_act)
            act_r[gi] <= wdata[7:0];
        end
      end
    end
  endgenerate

  // event evaluation, only the current index is looked at
  logic        tmr_done;
  wire  [7:0]  cur_evt = evt_r[idx_r];
  wire  [7:0]  cur_act = act_r[idx_r];
  wire  [7:0]  target  = (drv_r == EAS_RUN) ?
                         (sel_r ? pre1_r : pre0_r) : 8'h00;
  wire         at_ref  = (drv_r == EAS_RUN) && (speed_r == target);
  wire         ev_true = (cur_evt == `EAS_EV_TRUE)
                       | ((cur_evt == `EAS_EV_ATREF) & at_ref)
                       | ((cur_evt == `EAS_EV_TMR0) & tmr_done);
  wire         active  = mode_r && (count_r != '0);
  wire         fire    = tick_r && active && ev_true;
  wire         tmr_go  = fire && (cur_act == `EAS_AC_TMR0);
  wire         last    = (idx_r == count_r - IW'(1));

  always_comb begin
    idx_nxt = idx_r;
    if (!active)
      idx_nxt = '0;
    else if (idx_r >= count_r)
      idx_nxt = '0;
    else if (fire)
      idx_nxt = last ? '0 : idx_r + IW'(1);
  end

  // a false event leaves index and outputs untouched for this scan
  always_ff @(posedge clk) begin
    if (!rstn) begin
      idx_r <= '0;
      sel_r <= 1'b0;
    end else begin
      idx_r <= idx_nxt;
      if (fire && cur_act == `EAS_AC_PRE0)
        sel_r <= 1'b0;
      else if (fire && cur_act == `EAS_AC_PRE1)
        sel_r <= 1'b1;
    end
  end

  eas_timer u_tmr0 (
    .clk     (clk),
    .rstn    (rstn),
    .tick    (tick_r),
    .start   (tmr_go),
    .load    (tmr0_r),
    .expired (tmr_done)
  );

  // terminal decode
  wire  t18_lvl  = (t18_r == `EAS_T18_START);
  wire  t18_lat  = (t18_r == `EAS_T18_LATCH);
  wire  stop_n   = (t27_r == `EAS_T27_STOPN) ? s27_r[1] : 1'b1;
  wire  coast    = (t27_r == `EAS_T27_COAST) && !s27_r[1];
  wire  pulse18  = s18_r[1] && !s18_d_r;

  // latched start is set by a start pulse and dropped by stop inverse low
  always_ff @(posedge clk) begin
    if (!rstn)
      latch_r <= 1'b0;
    else if (!t18_lat || !stop_n || coast)
      latch_r <= 1'b0;
    else if (pulse18)
      latch_r <= 1'b1;
  end

  wire  run_cmd = (t18_lvl ? s18_r[1] : latch_r) && stop_n;

  // drive state: ramp toward target, ramp down on stop, then free
  always_comb begin
    drv_nxt   = drv_r;
    speed_nxt = speed_r;
    case (drv_r)
      EAS_FREE: begin
        speed_nxt = 8'h00;
        if (run_cmd && !coast)
          drv_nxt = EAS_RUN;
      end
      EAS_RUN: begin
        if (coast) begin
          drv_nxt   = EAS_FREE;
          speed_nxt = 8'h00;
        end else if (!run_cmd) begin
          drv_nxt = EAS_STOP;
        end else if (tick_r && speed_r < target) begin
          speed_nxt = speed_r + `EAS_RAMP_STEP;
        end else if (tick_r && speed_r > target) begin
          speed_nxt = speed_r - `EAS_RAMP_STEP;
        end
      end
      EAS_STOP: begin
        if (coast || speed_r == 8'h00) begin
          drv_nxt   = EAS_FREE;
          speed_nxt = 8'h00;
        end else if (run_cmd) begin
          drv_nxt = EAS_RUN;
        end else if (tick_r) begin
          speed_nxt = speed_r - `EAS_RAMP_STEP;
        end
      end
      default: begin
        drv_nxt   = EAS_FREE;
        speed_nxt = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      drv_r   <= EAS_FREE;
      speed_r <= 8'h00;
    end else begin
      drv_r   <= drv_nxt;
      speed_r <= speed_nxt;
    end
  end

  // read path
  wire [31:0] status = (32'(drv_r != EAS_FREE) << `EAS_ST_RUN)
                     | (32'(sel_r)    << `EAS_ST_SEL)
                     | (32'(tmr_done) << `EAS_ST_TDONE)
                     | (32'(at_ref)   << `EAS_ST_ATREF)
                     | (32'(idx_r)    << `EAS_ST_IDX)
                     | (32'(speed_r)  << `EAS_ST_SPEED);
  logic [31:0] rmux;

  always_comb begin
    rmux = 32'h0000_0000;
    if (in_evt && e_ok)
      rmux = {24'h0, evt_r[e_ix]};
    else if (in_act && e_ok)
      rmux = {24'h0, act_r[e_ix]};
    else begin
      case (addr)
        `EAS_A_CTRL:    rmux = {31'h0, mode_r};
        `EAS_A_COUNT:   rmux = {27'h0, count_r};
        `EAS_A_TIMER0:  rmux = {16'h0, tmr0_r};
        `EAS_A_PRESET0: rmux = {24'h0, pre0_r};
        `EAS_A_PRESET1: rmux = {24'h0, pre1_r};
        `EAS_A_TERM18:  rmux = {24'h0, t18_r};
        `EAS_A_TERM27:  rmux = {24'h0, t27_r};
        `EAS_A_STATUS:  rmux = status;
        default:        rmux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn)
      rdata_r <= 32'h0000_0000;
    else
      rdata_r <= rd ? rmux : 32'h0000_0000;
  end

  // outputs: drv_on and ref_sel registered copies
  logic drv_on_r;

  always_ff @(posedge clk) begin
    if (!rstn)
      drv_on_r <= 1'b0;
    else
      drv_on_r <= (drv_nxt != EAS_FREE);
  end

  assign rdata     = rdata_r;
  assign drv_on    = drv_on_r;
  assign speed     = speed_r;
  assign ref_sel   = sel_r;
  assign scan_tick = tick_r;

  // unused decode terms kept out of the logic
  wire unused_ok = &{1'b0, win_idx, ent, ent_i};
endmodule

// ---- tb/eas_seq_sva.sv ----
/*
  Port-level properties of the event/action sequencer.
  Assumes it is bound to eas_seq and that everything runs on one clock.
*/
`timescale 1ns/1ps
module eas_seq_sva #(
  parameter int SCAN_CYC = 8      // clocks per scan tick
) (
  input wire logic        clk,       // system clock
  input wire logic        rstn,      // synchronous reset, active low
  input wire logic [7:0]  addr,      // register address
  input wire logic [31:0] wdata,     // register write data
  input wire logic        wr,        // write strobe
  input wire logic        rd,        // read strobe
  input wire logic [31:0] rdata,     // read data
  input wire logic        din18,     // start pin
  input wire logic        din27,     // second pin
  input wire logic        drv_on,    // output stage powered
  input wire logic [7:0]  speed,     // actual speed
  input wire logic        ref_sel,   // active preset
  input wire logic        scan_tick  // scan tick pulse
);
  logic [15:0] gap_r;
  logic        seen_r;
  // the first tick after reset has a longer lead, so only later gaps count
  always_ff @(posedge clk) begin
    if (!rstn) begin
      gap_r  <= 16'h0000;
      seen_r <= 1'b0;
    end else begin
      gap_r  <= scan_tick ? 16'h0000 : gap_r + 16'h0001;
      seen_r <= seen_r | scan_tick;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence no_read;
    !rd;
  endsequence
  sequence tick_seen;
    scan_tick && seen_r;
  endsequence
  tick_period_a: assert property (tick_seen |-> gap_r == SCAN_CYC - 1)
    else $error("scan tick period wrong");
  tick_pulse_a: assert property (scan_tick |=> !scan_tick)
    else $error("scan tick longer than one cycle");
  ref_on_tick_a: assert property ($changed(ref_sel) |-> $past(scan_tick))
    else $error("preset select moved outside a scan");
  speed_step_a: assert property ($changed(speed) |-> speed == 8'h00 ||
      $past(scan_tick) && (speed == $past(speed) + 8'h01 ||
      speed == $past(speed) - 8'h01))
    else $error("speed jumped or moved off tick");
  speed_cap_a: assert property (speed <= 8'h64)
    else $error("speed above full scale");
  free_at_zero_a: assert property ($fell(drv_on) |-> speed == 8'h00)
    else $error("output freed while turning");
  start_cause_a: assert property ($rose(drv_on) |-> $past(din18, 2) ||
      $past(din18, 3) || $past(din18, 4) || $past(din18, 5) || $past(din18, 6))
    else $error("drive started without start pin");
  rd_quiet_a: assert property (no_read |=> rdata == 32'h0)
    else $error("read data without read");
  reset_clear_a: assert property ($rose(rstn) |-> !drv_on && !ref_sel &&
      speed == 8'h00 && !scan_tick)
    else $error("outputs not clear after reset");
endmodule

bind eas_seq eas_seq_sva #(.SCAN_CYC(SCAN_CYC)) i_sva (
  .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .din18(din18), .din27(din27), .drv_on(drv_on),
  .speed(speed), .ref_sel(ref_sel), .scan_tick(scan_tick)
);

// ---- tb/eas_plc.sv ----
/*
  Controller model that drives the two terminal pins of the drive.
  Assumes requests arrive on clk from the testbench.
*/
`timescale 1ns/1ps
module eas_plc (
  input  wire logic clk,     // system clock
  input  wire logic hold_on, // keep the start pin high
  input  wire logic kick,    // ask for one start pulse
  input  wire logic stop_n,  // level for the second pin
  output logic      din18,   // start pin
  output logic      din27    // second pin
);
  logic [2:0] pulse_r = 3'h0;
  // pulse spans six clocks so it survives the pin synchroniser
  always_ff @(posedge clk) begin
    pulse_r <= kick ? 3'h6 : (pulse_r != 3'h0 ? pulse_r - 3'h1 : 3'h0);
  end
  assign din18 = hold_on | (pulse_r != 3'h0);
  assign din27 = stop_n;
endmodule

// ---- tb/eas_seq_tb_top.sv ----
/*
  Self-checking bench for the event/action sequencer.
  Assumes eas_plc drives the pins and the checker is bound separately.
*/
`timescale 1ns/1ps
`include "eas_map.svh"
module eas_seq_tb_top;
  localparam int SC = 8;
  localparam logic [7:0] EV [4] = '{`EAS_EV_TRUE, `EAS_EV_ATREF,
                                    `EAS_EV_TMR0, `EAS_EV_FALSE};
  localparam logic [7:0] AC [4] = '{`EAS_AC_PRE0, `EAS_AC_TMR0,
                                    `EAS_AC_PRE1, `EAS_AC_NONE};
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        hold_on = 1'b0;
  logic        kick = 1'b0;
  logic        stop_n = 1'b0;
  logic [31:0] rdata;
  logic [7:0]  speed;
  logic        din18, din27, drv_on, ref_sel, scan_tick;
  logic [31:0] st;
  int          mismatches = 0;
  int          n_checks = 0;
  int          n_tick = 0;
  int          t0;
  int          i;

  always #2 clk = ~clk;
  always @(posedge clk) if (scan_tick === 1'b1) n_tick <= n_tick + 1;

  eas_seq #(.MAX_PAIRS(20), .SCAN_CYC(SC)) i_dut (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .din18(din18), .din27(din27), .drv_on(drv_on),
    .speed(speed), .ref_sel(ref_sel), .scan_tick(scan_tick));
  eas_plc i_plc (.clk(clk), .hold_on(hold_on), .kick(kick),
    .stop_n(stop_n), .din18(din18), .din27(din27));

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic wreg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rchk(string nm, logic [7:0] a, logic [31:0] exp);
    logic [31:0] d;
    rreg(a, d);
    chk(nm, exp, d);
  endtask
  task automatic wait_idx(logic [4:0] exp);
    int k;
    for (k = 0; k < 400; k++) begin
      rreg(`EAS_A_STATUS, st);
      if (st[12:8] === exp) return;
    end
    chk("pair index", {27'h0, exp}, {27'h0, st[12:8]});
    print_verdict();
  endtask
  task automatic wait_drv(logic exp);
    int k;
    for (k = 0; k < 2000; k++) begin
      @(posedge clk);
      if (drv_on === exp) return;
    end
    chk("drive state", {31'h0, exp}, {31'h0, drv_on});
    print_verdict();
  endtask
  // returns once the action of the tick just seen has landed
  task automatic next_tick();
    int k;
    for (k = 0; k < 4 * SC; k++) begin
      @(posedge clk);
      #1;
      if (scan_tick === 1'b1) begin
        @(posedge clk);
        #1;
        return;
      end
    end
    chk("scan tick", 32'h1, 32'h0);
    print_verdict();
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rchk("ctrl", `EAS_A_CTRL, 32'h0);
    rchk("count", `EAS_A_COUNT, 32'h0);
    rchk("timer0", `EAS_A_TIMER0, 32'h7d0);
    rchk("term18", `EAS_A_TERM18, 32'h8);
    rchk("term27", `EAS_A_TERM27, 32'h2);
    rchk("action0", `EAS_A_ACT_BASE, 32'h1);
    rchk("unmapped", 8'h20, 32'h0);
    wreg(`EAS_A_PRESET0, 32'hc8);
    rchk("preset clip", `EAS_A_PRESET0, 32'h64);
    wreg(`EAS_A_EVT_BASE + 8'h4c, 32'h1e);
    wreg(`EAS_A_ACT_BASE + 8'h4c, 32'h1d);
    rchk("event19", `EAS_A_EVT_BASE + 8'h4c, 32'h1e);
    rchk("action19", `EAS_A_ACT_BASE + 8'h4c, 32'h1d);
    wreg(`EAS_A_EVT_BASE + 8'h50, 32'h1);
    rchk("event20", `EAS_A_EVT_BASE + 8'h50, 32'h0);
    wreg(`EAS_A_COUNT, 32'h30);
    rchk("count clip", `EAS_A_COUNT, 32'h14);
    // start/ramp/hold/switch sequence, second pin ignored while held low
    wreg(`EAS_A_TERM27, {24'h0, `EAS_T27_NOP});
    wreg(`EAS_A_PRESET0, 32'h5);
    wreg(`EAS_A_PRESET1, 32'h0);
    wreg(`EAS_A_TIMER0, 32'h3);
    for (i = 0; i < 4; i++) begin
      wreg(`EAS_A_EVT_BASE + 8'(4 * i), {24'h0, EV[i]});
      wreg(`EAS_A_ACT_BASE + 8'(4 * i), {24'h0, AC[i]});
    end
    wreg(`EAS_A_COUNT, 32'h4);
    hold_on <= 1'b1;
    wait_drv(1'b1);
    wreg(`EAS_A_CTRL, 32'h1);
    wait_idx(5'h1);
    wait_idx(5'h2);
    t0 = n_tick;
    wait_idx(5'h3);
    chk("timer span", 32'h1, {31'h0, n_tick - t0 inside {[3:5]}});
    chk("preset one", 32'h1, {31'h0, ref_sel});
    repeat (3) next_tick();
    rreg(`EAS_A_STATUS, st);
    chk("held index", 32'h3, {27'h0, st[12:8]});
    // mode off, then first event false, then two true pairs wrapping
    wreg(`EAS_A_CTRL, 32'h0);
    next_tick();
    rreg(`EAS_A_STATUS, st);
    chk("index off", 32'h0, {27'h0, st[12:8]});
    wreg(`EAS_A_COUNT, 32'h2);
    wreg(`EAS_A_EVT_BASE, {24'h0, `EAS_EV_FALSE});
    wreg(`EAS_A_EVT_BASE + 8'h04, {24'h0, `EAS_EV_TRUE});
    wreg(`EAS_A_ACT_BASE + 8'h04, {24'h0, `EAS_AC_PRE1});
    wreg(`EAS_A_ACT_BASE, {24'h0, `EAS_AC_PRE0});
    wreg(`EAS_A_CTRL, 32'h1);
    repeat (2) next_tick();
    rreg(`EAS_A_STATUS, st);
    chk("first only", 32'h0, {27'h0, st[12:8]});
    chk("no action", 32'h1, {31'h0, ref_sel});
    next_tick();
    wreg(`EAS_A_EVT_BASE, {24'h0, `EAS_EV_TRUE});
    for (i = 0; i < 4; i++) begin
      next_tick();
      chk("wrap select", 32'(i % 2), {31'h0, ref_sel});
    end
    // level stop ramps down and frees the output
    hold_on <= 1'b0;
    wait_drv(1'b0);
    chk("stop speed", 32'h0, {24'h0, speed});
    // latched start by a pulse, stop by the second pin
    stop_n <= 1'b1;
    wreg(`EAS_A_TERM18, {24'h0, `EAS_T18_LATCH});
    wreg(`EAS_A_TERM27, {24'h0, `EAS_T27_STOPN});
    @(posedge clk);
    kick <= 1'b1;
    @(posedge clk);
    kick <= 1'b0;
    wait_drv(1'b1);
    repeat (20) @(posedge clk);
    chk("latched", 32'h1, {31'h0, drv_on});
    stop_n <= 1'b0;
    wait_drv(1'b0);
    chk("stopped", 32'h0, {24'h0, speed});
    print_verdict();
  end
endmodule
